// ===== verilog/cvx_exchange.sv
// Component variable exchange engine: table walker and link sequencer
`timescale 1ns/1ps
`default_nettype none
`include "cvx_regs.svh"

module cvx_exchange
    import cvx_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic        isWrite,
    input  wire logic [15:0] tableBase,
    output logic             memRead,
    output logic             memWrite,
    output logic [15:0]      memAddr,
    output logic [15:0]      memWdata,
    input  wire logic [15:0] memRdata,
    output logic             linkReq,
    output logic             linkWrite,
    output logic [7:0]       linkType,
    output logic [15:0]      linkVarAddr,
    output logic [31:0]      linkWdata,
    output logic             linkOpCmd,
    input  wire logic        linkDone,
    input  wire logic        linkTimeout,
    input  wire logic [7:0]  linkEndCode,
    input  wire logic [15:0] linkRespCode,
    input  wire logic [15:0] linkStatus,
    input  wire logic [31:0] linkRdata,
    output logic             busy,
    output logic             done,
    output logic             syntaxErr
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic bcdOk(input logic [15:0] v, input logic [15:0] lo);
        bcdOk = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v[11:8] <= 4'h9)
                && (v[15:12] <= 4'h9) && (v >= lo) && (v <= `CVX_CNT_MAX);
    endfunction

    function automatic logic [3:0] bcdToBin(input logic [15:0] v);
        bcdToBin = 4'((v[7:4] != 4'h0) ? (4'hA + v[3:0]) : v[3:0]);
    endfunction

    // Pair offset of variable n is 2n
    function automatic logic [15:0] pairOff(input logic [3:0] n);
        pairOff = {11'h000, n, 1'b0};
    endfunction

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    cvx_state_e  state_r;
    logic        isWrite_r;
    logic [15:0] base_r;
    logic [15:0] blk_r;
    logic [3:0]  count_r;
    logic        opCmd_r;
    logic [3:0]  varN_r;
    logic        half_r;
    logic        failed_r;
    logic [15:0] resp_r;
    logic [15:0] status_r;
    logic [31:0] rdata_r;
    logic        memRd_d;

    // A memory read issued in one cycle returns data the next cycle;
    // each table state waits one cycle on memRd_d before sampling.
    always_ff @(posedge clk)
    begin
        if (reset)
            memRd_d <= 1'b0;
        else
            memRd_d <= memRead && !memRd_d;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_r   <= CVX_IDLE;
            isWrite_r <= 1'b0;
            base_r    <= `CVX_ZERO16;
            blk_r     <= `CVX_ZERO16;
            count_r   <= 4'h0;
            opCmd_r   <= 1'b0;
            varN_r    <= 4'h0;
            half_r    <= 1'b0;
            failed_r  <= 1'b0;
            resp_r    <= `CVX_RESP_OK;
            status_r  <= `CVX_ZERO16;
            rdata_r   <= 32'h0000_0000;
            syntaxErr <= 1'b0;
            done      <= 1'b0;
            busy      <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_r)
                CVX_IDLE:
                begin
                    if (start)
                    begin
                        isWrite_r <= isWrite;
                        base_r    <= tableBase;
                        varN_r    <= 4'h1;
                        half_r    <= 1'b0;
                        failed_r  <= 1'b0;
                        resp_r    <= `CVX_RESP_OK;
                        syntaxErr <= 1'b0;
                        busy      <= 1'b1;
                        state_r   <= CVX_HDR0;
                    end
                end
                CVX_HDR0:
                begin
                    if (memRd_d)
                    begin
                        // Write count may be zero; read count may not
                        if (!bcdOk(memRdata, isWrite_r ? `CVX_ZERO16
                                                       : `CVX_CNT_MIN_RD))
                        begin
                            syntaxErr <= 1'b1;
                            state_r   <= CVX_DONE;
                        end
                        else
                        begin
                            count_r <= bcdToBin(memRdata);
                            state_r <= CVX_HDR1;
                        end
                    end
                end
                CVX_HDR1:
                begin
                    if (memRd_d)
                    begin
                        if (isWrite_r && memRdata != `CVX_OPCMD_OFF
                            && memRdata != `CVX_OPCMD_ON)
                        begin
                            syntaxErr <= 1'b1;
                            state_r   <= CVX_DONE;
                        end
                        else
                        begin
                            opCmd_r <= isWrite_r && memRdata == `CVX_OPCMD_ON;
                            state_r <= CVX_HDR2;
                        end
                    end
                end
                CVX_HDR2:
                begin
                    if (memRd_d)
                    begin
                        blk_r   <= memRdata;
                        state_r <= (count_r == 4'h0) ? CVX_LINK : CVX_TYPE;
                    end
                end
                CVX_TYPE:
                begin
                    if (memRd_d)
                    begin
                        if (memRdata < `CVX_TYPE_LO || memRdata > `CVX_TYPE_HI)
                        begin
                            syntaxErr <= 1'b1;
                            state_r   <= CVX_DONE;
                        end
                        else
                            state_r <= CVX_ADDR;
                    end
                end
                CVX_ADDR:
                begin
                    if (memRd_d)
                        state_r <= isWrite_r ? CVX_WLO : CVX_LINK;
                end
                CVX_WLO:
                begin
                    if (memRd_d)
                        state_r <= CVX_WHI;
                end
                CVX_WHI:
                begin
                    if (memRd_d)
                        state_r <= CVX_LINK;
                end
                CVX_LINK:
                begin
                    if (linkDone)
                    begin
                        status_r <= linkStatus;
                        rdata_r  <= linkRdata;
                        if (linkTimeout)
                            resp_r <= `CVX_RESP_TMO;
                        else if (linkEndCode == `CVX_ZERO8)
                            resp_r <= linkRespCode;
                        else
                            resp_r <= {`CVX_ERR_HI, linkEndCode};
                        if (linkTimeout || linkEndCode != `CVX_ZERO8
                            || linkRespCode != `CVX_RESP_OK)
                            failed_r <= 1'b1;
                        half_r  <= 1'b0;
                        if (isWrite_r)
                            state_r <= (linkTimeout || linkEndCode != `CVX_ZERO8
                                || linkRespCode != `CVX_RESP_OK
                                || varN_r >= count_r) ? CVX_RESP : CVX_TYPE;
                        else
                            state_r <= CVX_STORE;
                    end
                end
                CVX_STORE:
                begin
                    half_r <= !half_r;
                    if (half_r)
                    begin
                        if (varN_r >= count_r)
                            state_r <= CVX_RESP;
                        else if (failed_r)
                            state_r <= CVX_FILL;
                        else
                            state_r <= CVX_TYPE;
                    end
                end
                CVX_FILL:
                begin
                    half_r <= !half_r;
                    if (half_r && varN_r >= count_r)
                        state_r <= CVX_RESP;
                end
                CVX_RESP:
                    state_r <= isWrite_r ? CVX_DONE : CVX_STAT;
                CVX_STAT:
                    state_r <= CVX_DONE;
                CVX_DONE:
                begin
                    busy    <= 1'b0;
                    done    <= 1'b1;
                    state_r <= CVX_IDLE;
                end
                default:
                    state_r <= CVX_IDLE;
            endcase
            // Next variable, strictly ascending
            if ((state_r == CVX_LINK && linkDone && isWrite_r)
                || ((state_r == CVX_STORE || state_r == CVX_FILL) && half_r))
                varN_r <= varN_r + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Memory and link drive
    // ------------------------------------------------------------
    logic        failNow;
    assign failNow = failed_r;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            memRead  <= 1'b0;
            memWrite <= 1'b0;
            memAddr  <= `CVX_ZERO16;
            memWdata <= `CVX_ZERO16;
        end
        else
        begin
            memRead  <= 1'b0;
            memWrite <= 1'b0;
            case (state_r)
                CVX_HDR0, CVX_HDR1, CVX_HDR2, CVX_TYPE, CVX_ADDR,
                CVX_WLO, CVX_WHI:
                begin
                    memRead <= !memRd_d && !memRead;
                    if (state_r == CVX_HDR0)
                        memAddr <= base_r + `CVX_TBL_COUNT;
                    else if (state_r == CVX_HDR1)
                        memAddr <= base_r + `CVX_TBL_OPCMD;
                    else if (state_r == CVX_HDR2)
                        memAddr <= base_r + `CVX_TBL_START;
                    else if (state_r == CVX_TYPE)
                        memAddr <= base_r + `CVX_TYPE_BASE + pairOff(varN_r);
                    else if (state_r == CVX_ADDR)
                        memAddr <= base_r + `CVX_ADDR_BASE + pairOff(varN_r);
                    else if (state_r == CVX_WLO)
                        memAddr <= blk_r + pairOff(varN_r);
                    else
                        memAddr <= blk_r + pairOff(varN_r) + `CVX_PAIR_HI;
                end
                CVX_STORE, CVX_FILL:
                begin
                    memWrite <= 1'b1;
                    memAddr  <= blk_r + pairOff(varN_r)
                                + {15'h0000, half_r};
                    if (state_r == CVX_FILL || failNow)
                        memWdata <= `CVX_ZERO16;
                    else
                        memWdata <= half_r ? rdata_r[31:16]
                                           : rdata_r[15:0];
                end
                CVX_RESP:
                begin
                    memWrite <= 1'b1;
                    memAddr  <= blk_r + `CVX_BLK_RESP;
                    memWdata <= resp_r;
                end
                CVX_STAT:
                begin
                    memWrite <= 1'b1;
                    memAddr  <= blk_r + `CVX_BLK_STAT;
                    memWdata <= status_r;
                end
                default:
                begin
                end
            endcase
        end
    end

    // Table words are latched into link fields as they stream past
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            linkReq     <= 1'b0;
            linkWrite   <= 1'b0;
            linkType    <= `CVX_ZERO8;
            linkVarAddr <= `CVX_ZERO16;
            linkWdata   <= 32'h0000_0000;
            linkOpCmd   <= 1'b0;
        end
        else
        begin
            linkReq <= 1'b0;
            if (memRd_d && state_r == CVX_TYPE)
                linkType <= memRdata[7:0];
            if (memRd_d && state_r == CVX_ADDR)
                linkVarAddr <= memRdata;
            if (memRd_d && state_r == CVX_WLO)
                linkWdata[15:0] <= memRdata;
            if (memRd_d && state_r == CVX_WHI)
                linkWdata[31:16] <= memRdata;
            if (state_r == CVX_HDR2 && memRd_d)
                linkOpCmd <= opCmd_r;
            // One outstanding transaction only
            if (state_r != CVX_LINK && !linkReq
                && ((memRd_d && (state_r == CVX_WHI
                    || (state_r == CVX_ADDR && !isWrite_r)))
                    || (state_r == CVX_HDR2 && memRd_d && count_r == 4'h0)))
            begin
                linkReq   <= 1'b1;
                linkWrite <= isWrite_r;
            end
        end
    end

endmodule
`default_nettype wire

// ===== shared/cvx_regs.svh
// Offsets, codes and limits for the component variable exchange block
`ifndef CVX_REGS_SVH
`define CVX_REGS_SVH
`define CVX_TBL_COUNT      16'h0000
`define CVX_TBL_OPCMD      16'h0001
`define CVX_TBL_START      16'h0002
`define CVX_TYPE_BASE      16'h0001
`define CVX_ADDR_BASE      16'h0002
`define CVX_BLK_RESP       16'h0000
`define CVX_BLK_STAT       16'h0001
`define CVX_BLK_LAST       16'h0019
`define CVX_PAIR_HI        16'h0001
`define CVX_TYPE_LO        16'h00C0
`define CVX_TYPE_HI        16'h00CF
`define CVX_CNT_MIN_RD     16'h0001
`define CVX_CNT_MAX        16'h0012
`define CVX_OPCMD_OFF      16'h0000
`define CVX_OPCMD_ON       16'h0001
`define CVX_RESP_OK        16'h0000
`define CVX_RESP_TMO       16'hFFFF
`define CVX_RESP_SYNTAX    16'hFF0D
`define CVX_ERR_HI         8'hFF
`define CVX_ZERO16         16'h0000
`define CVX_ZERO8          8'h00
`define CVX_VAR_MAX        4'hC
`endif

// ===== shared/cvx_pkg.sv
// Types shared by the component variable exchange block
package cvx_pkg;
    typedef logic [15:0] cvx_word_t;
    typedef enum logic [3:0] {
        CVX_IDLE   = 4'b0000,
        CVX_HDR0   = 4'b0001,
        CVX_HDR1   = 4'b0010,
        CVX_HDR2   = 4'b0011,
        CVX_TYPE   = 4'b0100,
        CVX_ADDR   = 4'b0101,
        CVX_WLO    = 4'b0110,
        CVX_WHI    = 4'b0111,
        CVX_LINK   = 4'b1000,
        CVX_STORE  = 4'b1001,
        CVX_FILL   = 4'b1010,
        CVX_RESP   = 4'b1011,
        CVX_STAT   = 4'b1100,
        CVX_DONE   = 4'b1101
    } cvx_state_e;
endpackage

// ===== bench/cvx_exchange_props.sv
// Port-level assertions for the component variable exchange engine
`timescale 1ns/1ps
`default_nettype none
module cvx_exchange_props
    import cvx_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       start,
    input wire logic       busy,
    input wire logic       done,
    input wire logic       linkReq,
    input wire logic       linkDone,
    input wire logic [7:0] linkType,
    input wire logic       memRead,
    input wire logic       memWrite,
    input wire logic       syntaxErr
);
    // ------------------------------------------------------------
    // Outstanding link transaction tracker
    // ------------------------------------------------------------
    logic pend_r;
    always_ff @(posedge clk)
    begin
        if (reset)
            pend_r <= 1'b0;
        else if (linkReq)
            pend_r <= 1'b1;
        else if (linkDone)
            pend_r <= 1'b0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    start_taken_a:
        assert property (start && !busy |=> busy)
        else $error("start not taken");
    done_pulse_a:
        assert property (done |=> !done)
        else $error("done longer than one cycle");
    done_idle_a:
        assert property (done |-> ##[1:2] !busy)
        else $error("busy held after done");
    link_single_a:
        assert property (linkReq |-> !pend_r)
        else $error("second link request while one pending");
    link_type_a:
        assert property (linkReq |-> linkType[7:4] == 4'hC)
        else $error("link type outside allowed range");
    syntax_quiet_a:
        assert property (syntaxErr |-> !memWrite && !linkReq)
        else $error("activity after syntax error");
    mem_excl_a:
        assert property (!(memRead && memWrite))
        else $error("read and write strobes together");
    busy_cover_a:
        assert property (memRead || memWrite || linkReq |-> busy)
        else $error("activity while idle");
endmodule
bind cvx_exchange cvx_exchange_props u_cvx_exchange_props (
    .clk      (clk),
    .reset    (reset),
    .start    (start),
    .busy     (busy),
    .done     (done),
    .linkReq  (linkReq),
    .linkDone (linkDone),
    .linkType (linkType),
    .memRead  (memRead),
    .memWrite (memWrite),
    .syntaxErr(syntaxErr)
);
`default_nettype wire

// ===== bench/cvx_link_model.sv
// Behavioural model of the serial component on the far side of the link
`timescale 1ns/1ps
`default_nettype none
module cvx_link_model #(
    parameter logic [15:0] STAT = 16'h5A3C
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        linkReq,
    input  wire logic [7:0]  linkType,
    input  wire logic [15:0] linkVarAddr,
    input  wire logic [31:0] linkWdata,
    input  wire logic        linkOpCmd,
    input  wire logic [3:0]  failAt,
    input  wire logic [7:0]  failCode,
    input  wire logic        tmo,
    output logic             linkDone,
    output logic             linkTimeout,
    output logic [7:0]       linkEndCode,
    output logic [15:0]      linkRespCode,
    output logic [15:0]      linkStatus,
    output logic [31:0]      linkRdata,
    output logic [31:0]      gotWdata,
    output logic             gotOp,
    output logic [7:0]       gotType,
    output logic [15:0]      gotAddr
);
    localparam logic [15:0] RESP_REFUSE = 16'h2203;
    logic [2:0]  cnt;
    logic        hit;
    // Odd types answer slowly; results scramble outside the done cycle
    // so that a late sample by the engine cannot pass by luck
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            cnt          <= 3'h0;
            hit          <= 1'b0;
            linkDone     <= 1'b0;
            linkTimeout  <= 1'b0;
            linkEndCode  <= 8'h00;
            linkRespCode <= 16'h0000;
            linkStatus   <= 16'h0000;
            linkRdata    <= 32'h0000_0000;
        end
        else if (cnt == 3'h1 && !linkReq)
        begin
            cnt          <= 3'h0;
            linkDone     <= 1'b1;
            linkTimeout  <= hit & tmo;
            linkEndCode  <= (hit & !tmo) ? failCode : 8'h00;
            linkRespCode <= (hit & !tmo & failCode == 8'h00)
                            ? RESP_REFUSE : 16'h0000;
            linkStatus   <= STAT;
            linkRdata    <= {gotAddr, ~gotAddr};
        end
        else
        begin
            linkDone     <= 1'b0;
            linkTimeout  <= ~linkTimeout;
            linkEndCode  <= ~linkEndCode;
            linkRespCode <= ~linkRespCode;
            linkStatus   <= ~linkStatus;
            linkRdata    <= ~linkRdata;
            if (linkReq)
            begin
                cnt      <= linkType[0] ? 3'h6 : 3'h1;
                hit      <= linkType[3:0] == failAt;
                gotWdata <= linkWdata;
                gotOp    <= linkOpCmd;
                gotType  <= linkType;
                gotAddr  <= linkVarAddr;
            end
            else if (cnt != 3'h0)
                cnt <= cnt - 3'h1;
        end
    end
endmodule
`default_nettype wire

// ===== bench/cvx_exchange_tb.sv
// Self-checking testbench for the component variable exchange engine
`timescale 1ns/1ps
`default_nettype none
module cvx_exchange_tb;
    import cvx_pkg::*;
    localparam logic [15:0] STAT_V = 16'h5A3C;
    logic clk, reset, start, isWrite, memRead, memWrite, linkReq;
    logic linkWrite, linkOpCmd, linkDone, linkTimeout, busy, done;
    logic syntaxErr, tmo, gotOp, seenWr;
    logic [15:0] tableBase, memAddr, memWdata, memRdata, linkVarAddr;
    logic [15:0] linkRespCode, linkStatus, gotAddr;
    logic [7:0]  linkType, linkEndCode, failCode, gotType;
    logic [31:0] linkWdata, linkRdata, gotWdata;
    logic [3:0]  failAt;
    logic [15:0] mem [0:255];
    int miscompares, n_checks, nWr;
    cvx_exchange u_cvx_exchange (.clk(clk), .reset(reset), .start(start),
        .isWrite(isWrite), .tableBase(tableBase), .memRead(memRead),
        .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
        .memRdata(memRdata), .linkReq(linkReq), .linkWrite(linkWrite),
        .linkType(linkType), .linkVarAddr(linkVarAddr),
        .linkWdata(linkWdata), .linkOpCmd(linkOpCmd), .linkDone(linkDone),
        .linkTimeout(linkTimeout), .linkEndCode(linkEndCode),
        .linkRespCode(linkRespCode), .linkStatus(linkStatus),
        .linkRdata(linkRdata), .busy(busy), .done(done),
        .syntaxErr(syntaxErr));
    cvx_link_model #(.STAT(STAT_V)) u_cvx_link_model (.clk(clk),
        .reset(reset), .linkReq(linkReq), .linkType(linkType),
        .linkVarAddr(linkVarAddr), .linkWdata(linkWdata),
        .linkOpCmd(linkOpCmd), .failAt(failAt), .failCode(failCode),
        .tmo(tmo), .linkDone(linkDone), .linkTimeout(linkTimeout),
        .linkEndCode(linkEndCode), .linkRespCode(linkRespCode),
        .linkStatus(linkStatus), .linkRdata(linkRdata),
        .gotWdata(gotWdata), .gotOp(gotOp), .gotType(gotType),
        .gotAddr(gotAddr));
    // ------------------------------------------------------------
    // Clock and data_memory model
    // ------------------------------------------------------------
    always #2 clk = ~clk;
    always @(posedge clk)
    begin
        if (memRead === 1'b1)
            memRdata <= mem[memAddr[7:0]];
        if (memWrite === 1'b1)
        begin
            mem[memAddr[7:0]] <= memWdata;
            nWr++;
        end
        if (linkReq === 1'b1)
            seenWr <= linkWrite;
    end
    task print_verdict;
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            miscompares++;
        end
    endtask
    // Table at 0x10; variable i gets type C0+i, address 0100+i
    task automatic fill(input logic [15:0] n, op, blk, input int nv);
        mem[16] = n;
        mem[17] = op;
        mem[18] = blk;
        for (int i = 1; i <= nv; i++)
        begin
            mem[17+2*i] = 16'h00C0 + i[15:0];
            mem[18+2*i] = 16'h0100 + i[15:0];
        end
    endtask
    task automatic run(input logic w);
        int k;
        @(posedge clk);
        start     <= 1'b1;
        isWrite   <= w;
        tableBase <= 16'h0010;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 3000)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 3000)
        begin
            miscompares++;
            print_verdict;
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_read_full;
        fill(16'h0012, 16'h0000, 16'h0040, 12);
        run(1'b0);
        for (int i = 1; i <= 12; i++)
        begin
            chk("lo", ~(16'h0100 + i[15:0]), mem[64+2*i]);
            chk("hi", 16'h0100 + i[15:0], mem[65+2*i]);
        end
        chk("resp", 16'h0000, mem[64]);
        chk("stat", STAT_V, mem[65]);
        chk("lwr", 16'h0000, {15'h0000, seenWr});
    endtask
    task automatic t_read_err;
        fill(16'h0003, 16'h0000, 16'h0040, 3);
        for (int i = 66; i < 72; i++)
            mem[i] = 16'hDEAD;
        failAt = 4'h2;
        failCode = 8'h16;
        run(1'b0);
        failAt = 4'h0;
        chk("lo1", 16'hFEFE, mem[66]);
        chk("hi1", 16'h0101, mem[67]);
        for (int i = 68; i < 72; i++)
            chk("zero", 16'h0000, mem[i]);
        chk("resp", 16'hFF16, mem[64]);
    endtask
    task automatic t_read_tmo;
        fill(16'h0001, 16'h0000, 16'h0040, 1);
        mem[66] = 16'hDEAD;
        tmo = 1'b1;
        failAt = 4'h1;
        run(1'b0);
        tmo = 1'b0;
        chk("resp", 16'hFFFF, mem[64]);
        chk("lo1", 16'h0000, mem[66]);
        // Clean end code but a refusing response code
        mem[67] = 16'hDEAD;
        failCode = 8'h00;
        run(1'b0);
        failAt = 4'h0;
        chk("rcode", 16'h2203, mem[64]);
        chk("hi1", 16'h0000, mem[67]);
    endtask
    task automatic t_bad;
        int w0;
        for (int j = 0; j < 3; j++)
        begin
            case (j)
                0: fill(16'h0001, 16'h0001, 16'h0060, 1);
                1: fill(16'h0013, 16'h0000, 16'h0040, 1);
                default: fill(16'h0001, 16'h0002, 16'h0060, 1);
            endcase
            if (j == 0)
                mem[19] = 16'h00D0;
            w0 = nWr;
            run(j != 1);
            chk("serr", 16'h0001, {15'h0000, syntaxErr});
            chk("nwr", w0[15:0], nWr[15:0]);
        end
    endtask
    task automatic t_write;
        fill(16'h0001, 16'h0001, 16'h0060, 1);
        mem[96] = 16'hDEAD;
        mem[98] = 16'h1234;
        mem[99] = 16'h8765;
        run(1'b1);
        chk("wlo", 16'h1234, gotWdata[15:0]);
        chk("whi", 16'h8765, gotWdata[31:16]);
        chk("type", 16'h00C1, {8'h00, gotType});
        chk("vadr", 16'h0101, gotAddr);
        chk("op", 16'h0001, {15'h0000, gotOp});
        chk("resp", 16'h0000, mem[96]);
        chk("lwr", 16'h0001, {15'h0000, seenWr});
        // Count zero sends the command word alone
        fill(16'h0000, 16'h0000, 16'h0060, 0);
        mem[96] = 16'hDEAD;
        run(1'b1);
        chk("op0", 16'h0000, {15'h0000, gotOp});
        chk("resp0", 16'h0000, mem[96]);
    endtask
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        start = 1'b0;
        isWrite = 1'b0;
        tableBase = 16'h0000;
        failAt = 4'h0;
        failCode = 8'h00;
        tmo = 1'b0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        t_read_full;
        t_read_err;
        t_read_tmo;
        t_bad;
        t_write;
        print_verdict;
    end
endmodule
`default_nettype wire
